// file: hw/fcs_flash_cmd.sv
// flash command launch, buffering and status tracking
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - launch via empty flag, clears complete flag
// - empty flag reflects buffer handed to array
// - only burst programs queue, behind a running burst
// - complete flag: buffer empty and idle
// - writes to complete flag ignored
// - protected target: ignore, set violation flag
// - broken write sequence sets access error
// - program or erase before divider write errs
// - stop mode during command sets access error
// - access error cleared by writing one
// - blank check pass sets blank flag
// - blank flag cleared by valid launch or failing blank check
// - decode blank, byte and burst codes
// - decode page and mass erase codes
// - other codes are illegal, access error
// - passing blank check unsecures the part
// - refuse program/erase in protected region
module fcs_flash_cmd (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic [fcs_pkg::ADDR_W-1:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_write,
  input wire logic i_read,
  output logic [7:0] o_rdata,
  input wire logic i_stop_mode,
  input wire logic i_array_done,
  input wire logic i_array_blank,
  output logic o_array_start,
  output fcs_pkg::fcs_op_t o_array_op,
  output logic [15:0] o_array_addr,
  output logic [7:0] o_array_data,
  output logic [1:0] o_security_state,
  output logic o_irq
);
  import fcs_pkg::*;

  typedef struct packed {
    fcs_seq_t seq;
    logic div_written;
    logic [7:0] divider;
    logic [7:0] prot;
    logic [7:0] addr_hi;
    logic [7:0] addr_lo;
    logic [7:0] data;
    logic [7:0] cmd;
    logic buf_valid;
    fcs_op_t buf_op;
    logic [15:0] buf_addr;
    logic [7:0] buf_data;
    logic exec_busy;
    fcs_op_t exec_op;
    logic blank;
    logic ccf_prev;
    logic [1:0] security;
    logic [IRQ_W-1:0] irq_mask;
    logic stop_prev;
    logic start;
    fcs_op_t start_op;
    logic [15:0] start_addr;
    logic [7:0] start_data;
    logic [7:0] rdata;
    logic irq;
  } fcs_state_t;

  fcs_state_t st;
  fcs_state_t next_st;

  fcs_op_t dec_op;
  logic dec_legal;
  logic dec_prog_erase;
  logic dec_protected;
  logic [15:0] seq_addr;
  logic [1:0] err_flags;
  logic [1:0] err_set;
  logic [1:0] err_clear;
  logic [IRQ_W-1:0] irq_flags;
  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_clear;
  logic wr_status;
  logic launch;
  logic launch_ok;
  logic transfer;
  logic ccf;
  logic cmd_buffer_empty_flag;
  logic stop_entry;
  logic blank_done;

  assign seq_addr = {st.addr_hi, st.addr_lo};

  fcs_cmd_decode u_decode (
    .i_code(st.cmd),
    .i_addr(seq_addr),
    .i_prot(st.prot),
    .o_op(dec_op),
    .o_legal(dec_legal),
    .o_prog_erase(dec_prog_erase),
    .o_protected(dec_protected)
  );

  // bit 1 protection violation, bit 0 access error
  fcs_sticky #(
    .W(2)
  ) u_err_flags (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_set(err_set),
    .i_clear(err_clear),
    .o_flags(err_flags)
  );

  fcs_sticky #(
    .W(IRQ_W)
  ) u_irq_flags (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_set(irq_set),
    .i_clear(irq_clear),
    .o_flags(irq_flags)
  );

  assign cmd_buffer_empty_flag = !st.buf_valid;
  // complete when nothing buffered or running
  assign ccf = !st.buf_valid && !st.exec_busy;
  assign wr_status = i_write && (i_addr == OFF_STATUS);
  // launch by writing one to the empty flag
  assign launch = wr_status && i_wdata[BIT_CBEF] && (st.seq == SEQ_CMD);
  assign stop_entry = i_stop_mode && !st.stop_prev && !ccf;
  assign blank_done = i_array_done && st.exec_busy && (st.exec_op == OP_BLANK);
  // the buffer hands over when the array is free or finishing
  assign transfer = st.buf_valid && (!st.exec_busy || i_array_done);

  always_comb begin
    err_set = 2'h0;
    launch_ok = 1'b0;
    if (i_write) begin
      if ((i_addr == OFF_DATA) && !cmd_buffer_empty_flag) begin
        err_set[0] = 1'b1;
      end
      if ((i_addr == OFF_COMMAND) && (st.seq != SEQ_DATA)) begin
        err_set[0] = 1'b1;
      end
      if (wr_status && i_wdata[BIT_CBEF] && (st.seq != SEQ_CMD)) begin
        err_set[0] = 1'b1;
      end
    end
    if (launch) begin
      if (!dec_legal) begin
        err_set[0] = 1'b1;
      end else if (dec_prog_erase && !st.div_written) begin
        err_set[0] = 1'b1;
      end else if (dec_protected) begin
        err_set[1] = 1'b1;
      end else if (!cmd_buffer_empty_flag || (st.exec_busy && !(dec_op == OP_BURST && st.exec_op == OP_BURST))) begin
        // only bursts queue behind a running burst
        err_set[0] = 1'b1;
      end else begin
        launch_ok = 1'b1;
      end
    end
    if (stop_entry) begin
      err_set[0] = 1'b1;
    end
  end

  // write one clears errors, zero does nothing
  assign err_clear = wr_status ? {i_wdata[BIT_PVIOL], i_wdata[BIT_ACCERR]} : 2'h0;
  assign irq_clear = (i_write && (i_addr == OFF_IRQ_STATUS)) ? i_wdata[IRQ_W-1:0] : '0;

  always_comb begin
    irq_set = '0;
    irq_set[IRQ_COMPLETE] = ccf && !st.ccf_prev;
    irq_set[IRQ_PVIOL] = err_set[1];
    irq_set[IRQ_ACCERR] = err_set[0];
    irq_set[IRQ_BLANK] = blank_done && i_array_blank;
  end

  always_comb begin
    next_st = st;
    next_st.stop_prev = i_stop_mode;
    next_st.ccf_prev = ccf;
    next_st.start = 1'b0;
    next_st.rdata = 8'h00;
    next_st.irq = |(irq_flags & st.irq_mask);
    if (i_write) begin
      case (i_addr)
        OFF_DIVIDER: begin
          next_st.divider = i_wdata;
          next_st.div_written = 1'b1;
        end
        OFF_PROT: next_st.prot = i_wdata;
        OFF_ADDR_HI: next_st.addr_hi = i_wdata;
        OFF_ADDR_LO: next_st.addr_lo = i_wdata;
        OFF_DATA: begin
          if (cmd_buffer_empty_flag) begin
            next_st.data = i_wdata;
            next_st.seq = SEQ_DATA;
          end else begin
            next_st.seq = SEQ_IDLE;
          end
        end
        OFF_COMMAND: begin
          if (st.seq == SEQ_DATA) begin
            next_st.cmd = i_wdata;
            next_st.seq = SEQ_CMD;
          end else begin
            next_st.seq = SEQ_IDLE;
          end
        end
        // complete flag bit has no write path here
        OFF_STATUS: begin
          if (i_wdata[BIT_CBEF]) begin
            next_st.seq = SEQ_IDLE;
          end
        end
        OFF_IRQ_MASK: next_st.irq_mask = i_wdata[IRQ_W-1:0];
        default: next_st.seq = st.seq;
      endcase
    end
    if (i_read) begin
      case (i_addr)
        OFF_STATUS: begin
          next_st.rdata[BIT_CBEF] = cmd_buffer_empty_flag;
          next_st.rdata[BIT_CCF] = ccf;
          next_st.rdata[BIT_PVIOL] = err_flags[1];
          next_st.rdata[BIT_ACCERR] = err_flags[0];
          next_st.rdata[BIT_BLANK] = st.blank;
        end
        OFF_DIVIDER: next_st.rdata = st.divider;
        OFF_PROT: next_st.rdata = st.prot;
        OFF_ADDR_HI: next_st.rdata = st.addr_hi;
        OFF_ADDR_LO: next_st.rdata = st.addr_lo;
        OFF_DATA: next_st.rdata = st.data;
        OFF_COMMAND: next_st.rdata = st.cmd;
        OFF_IRQ_STATUS: next_st.rdata[IRQ_W-1:0] = irq_flags;
        OFF_IRQ_MASK: next_st.rdata[IRQ_W-1:0] = st.irq_mask;
        OFF_SECURITY: next_st.rdata[1:0] = st.security;
        default: next_st.rdata = 8'h00;
      endcase
    end
    // array finishing frees the engine unless a handover follows
    if (i_array_done && st.exec_busy) begin
      next_st.exec_busy = 1'b0;
      next_st.exec_op = OP_NONE;
    end
    if (blank_done) begin
      next_st.blank = i_array_blank;
      if (i_array_blank) begin
        next_st.security = SEC_UNSECURED;
      end
    end
    if (transfer) begin
      next_st.buf_valid = 1'b0;
      next_st.exec_busy = 1'b1;
      next_st.exec_op = st.buf_op;
      next_st.start = 1'b1;
      next_st.start_op = st.buf_op;
      next_st.start_addr = st.buf_addr;
      next_st.start_data = st.buf_data;
    end
    if (launch_ok) begin
      next_st.buf_valid = 1'b1;
      next_st.buf_op = dec_op;
      next_st.buf_addr = seq_addr;
      next_st.buf_data = st.data;
      // blank flag cleared by a valid launch
      next_st.blank = 1'b0;
    end
    // a pending command is dropped on stop; a running one is left to finish
    if (stop_entry) begin
      next_st.buf_valid = 1'b0;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st <= '{seq: SEQ_IDLE, div_written: 1'b0, divider: RST_DIVIDER, prot: RST_PROT,
              addr_hi: RST_BYTE, addr_lo: RST_BYTE, data: RST_BYTE, cmd: RST_BYTE,
              buf_valid: 1'b0, buf_op: OP_NONE, buf_addr: 16'h0000, buf_data: RST_BYTE,
              exec_busy: 1'b0, exec_op: OP_NONE, blank: 1'b0, ccf_prev: 1'b1,
              security: SEC_SECURED, irq_mask: RST_IRQ_MASK, stop_prev: 1'b0,
              start: 1'b0, start_op: OP_NONE, start_addr: 16'h0000, start_data: RST_BYTE,
              rdata: RST_BYTE, irq: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign o_rdata = st.rdata;
  assign o_array_start = st.start;
  assign o_array_op = st.start_op;
  assign o_array_addr = st.start_addr;
  assign o_array_data = st.start_data;
  assign o_security_state = st.security;
  assign o_irq = st.irq;

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);

  sequence s_idle_launch;
    launch_ok && !st.exec_busy && !st.buf_valid;
  endsequence

  sequence s_handover;
    !ccf ##1 (st.start && !ccf);
  endsequence

  launch_ccf_clear_a: assert property (s_idle_launch |=> s_handover)
    else $error("launch did not clear complete flag and start array");
  launch_fills_a: assert property (launch_ok |=> !cmd_buffer_empty_flag)
    else $error("accepted launch left buffer empty");
  handover_empty_a: assert property (st.start |-> cmd_buffer_empty_flag)
    else $error("buffer not empty after handover");
  ccf_busy_a: assert property (o_array_start |-> !ccf [*2])
    else $error("complete flag high while array starts");
  ccf_write_a: assert property (wr_status && !launch_ok && !transfer && !i_array_done |=> ccf == $past(ccf))
    else $error("status write changed complete flag");
  pviol_set_a: assert property (launch && dec_legal && (!dec_prog_erase || st.div_written) && dec_protected
    |=> err_flags[1] && !st.start)
    else $error("protected launch not flagged or not ignored");
  seq_order_a: assert property (i_write && (i_addr == OFF_COMMAND) && (st.seq == SEQ_IDLE) |=> err_flags[0])
    else $error("command without data step not flagged");
  div_unset_a: assert property (launch && dec_prog_erase && !st.div_written |=> err_flags[0] && !st.buf_valid)
    else $error("launch before divider write not flagged");
  stop_err_a: assert property ($rose(i_stop_mode) && !ccf |=> err_flags[0])
    else $error("stop during command not flagged");
  acc_clear_a: assert property (wr_status && i_wdata[BIT_ACCERR] && !err_set[0] |=> !err_flags[0])
    else $error("access error not cleared by one");
  acc_keep_a: assert property (wr_status && !i_wdata[BIT_ACCERR] && err_flags[0] |=> err_flags[0])
    else $error("access error cleared by zero");
  blank_result_a: assert property (blank_done && !launch_ok |=> st.blank == $past(i_array_blank))
    else $error("blank flag does not follow blank check result");
  blank_launch_a: assert property (launch_ok |=> !st.blank)
    else $error("blank flag kept over valid launch");
  illegal_code_a: assert property (launch && !dec_legal |=> err_flags[0] ##1 !st.start)
    else $error("illegal code not flagged");
  unsecure_a: assert property (blank_done && i_array_blank |=> o_security_state == SEC_UNSECURED)
    else $error("blank pass did not unsecure");
endmodule // fcs_flash_cmd
`default_nettype wire

// file: pkg/fcs_pkg.sv
// shared constants and types of the flash command and status block
package fcs_pkg;
  localparam int unsigned ADDR_W = 4;
  localparam logic [3:0] OFF_STATUS = 4'h0;
  localparam logic [3:0] OFF_COMMAND = 4'h1;
  localparam logic [3:0] OFF_DIVIDER = 4'h2;
  localparam logic [3:0] OFF_PROT = 4'h3;
  localparam logic [3:0] OFF_ADDR_HI = 4'h4;
  localparam logic [3:0] OFF_ADDR_LO = 4'h5;
  localparam logic [3:0] OFF_DATA = 4'h6;
  localparam logic [3:0] OFF_IRQ_STATUS = 4'h7;
  localparam logic [3:0] OFF_IRQ_MASK = 4'h8;
  localparam logic [3:0] OFF_SECURITY = 4'h9;
  // flash_status bit positions
  localparam int unsigned BIT_CBEF = 7;
  localparam int unsigned BIT_CCF = 6;
  localparam int unsigned BIT_PVIOL = 5;
  localparam int unsigned BIT_ACCERR = 4;
  localparam int unsigned BIT_BLANK = 2;
  // interrupt status bit positions
  localparam int unsigned IRQ_COMPLETE = 0;
  localparam int unsigned IRQ_PVIOL = 1;
  localparam int unsigned IRQ_ACCERR = 2;
  localparam int unsigned IRQ_BLANK = 3;
  localparam int unsigned IRQ_W = 4;
  // command codes
  localparam logic [7:0] BLANK_CHECK_CODE = 8'h05;
  localparam logic [7:0] BYTE_PROGRAM_CODE = 8'h20;
  localparam logic [7:0] BURST_PROGRAM_CODE = 8'h25;
  localparam logic [7:0] PAGE_ERASE_CODE = 8'h40;
  localparam logic [7:0] MASS_ERASE_CODE = 8'h41;
  localparam int unsigned PAGE_BYTES = 512;
  localparam int unsigned PAGE_SHIFT = $clog2(PAGE_BYTES);
  // reset values
  localparam logic [7:0] RST_DIVIDER = 8'h00;
  localparam logic [7:0] RST_PROT = 8'h01;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [IRQ_W-1:0] RST_IRQ_MASK = 4'h0;
  localparam logic [1:0] SEC_SECURED = 2'h3;
  localparam logic [1:0] SEC_UNSECURED = 2'h2;
  typedef enum logic [2:0] {OP_NONE, OP_BLANK, OP_BYTE, OP_BURST, OP_PAGE, OP_MASS} fcs_op_t;
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_DATA, SEQ_CMD} fcs_seq_t;
endpackage

// file: hw/fcs_sticky.sv
// sticky write-one-to-clear flag bank where a set beats a clear
`timescale 1ns/1ps
`default_nettype none
module fcs_sticky #(
  parameter int unsigned W = 2
) (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic [W-1:0] i_set,
  input wire logic [W-1:0] i_clear,
  output logic [W-1:0] o_flags
);
  typedef struct packed {
    logic [W-1:0] flags;
  } fcs_sticky_t;
  fcs_sticky_t st;
  fcs_sticky_t next_st;

  always_comb begin
    next_st = st;
    // an event in the clearing cycle is kept
    next_st.flags = (st.flags & ~i_clear) | i_set;
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_flags = st.flags;
endmodule // fcs_sticky
`default_nettype wire

// file: hw/fcs_cmd_decode.sv
// command code decode and block protection check
`timescale 1ns/1ps
`default_nettype none
module fcs_cmd_decode (
  input wire logic [7:0] i_code,
  input wire logic [15:0] i_addr,
  input wire logic [7:0] i_prot,
  output fcs_pkg::fcs_op_t o_op,
  output logic o_legal,
  output logic o_prog_erase,
  output logic o_protected
);
  import fcs_pkg::*;
  logic [6:0] page_top;

  always_comb begin
    o_op = OP_NONE;
    o_legal = 1'b1;
    case (i_code)
      BLANK_CHECK_CODE: o_op = OP_BLANK;
      BYTE_PROGRAM_CODE: o_op = OP_BYTE;
      BURST_PROGRAM_CODE: o_op = OP_BURST;
      PAGE_ERASE_CODE: o_op = OP_PAGE;
      MASS_ERASE_CODE: o_op = OP_MASS;
      default: o_legal = 1'b0;
    endcase
  end

  assign o_prog_erase = o_legal && (o_op != OP_BLANK);
  assign page_top = i_addr[15:PAGE_SHIFT];

  // protected region
  // locations above the boundary page are guarded; mass erase hits them all
  always_comb begin
    o_protected = 1'b0;
    if (!i_prot[0] && o_prog_erase) begin
      o_protected = (o_op == OP_MASS) || (page_top > i_prot[7:1]);
    end
  end
endmodule // fcs_cmd_decode
`default_nettype wire

// file: bench/fcs_array_model.sv
// behavioural flash array that answers operation starts with a done pulse
`timescale 1ns/1ps
`default_nettype none
module fcs_array_model (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_start,
  input wire logic i_slow,
  input wire logic i_blank_set,
  output logic o_done,
  output logic o_blank
);
  logic [6:0] cnt;
  logic busy;
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      busy <= 1'h0;
      cnt <= 7'h00;
      o_done <= 1'h0;
      o_blank <= 1'h0;
    end else begin
      o_done <= 1'h0;
      // outside done the blank line toggles so a stale value never passes
      o_blank <= ~o_blank;
      if (i_start) begin
        busy <= 1'h1;
        cnt <= i_slow ? 7'h28 : 7'h03;
      end else if (busy && cnt == 7'h00) begin
        busy <= 1'h0;
        o_done <= 1'h1;
        o_blank <= i_blank_set;
      end else if (busy) begin
        cnt <= cnt - 7'h01;
      end
    end
  end
endmodule // fcs_array_model
`default_nettype wire

// file: bench/tb_fcs_flash_cmd.sv
// self-checking testbench of the flash command and status block
`timescale 1ns/1ps
`default_nettype none
module tb_fcs_flash_cmd;
  import fcs_pkg::*;
  typedef struct {logic [7:0] code; logic blank; logic go; fcs_op_t op; logic [7:0] st;} fcs_row_t;
  logic clock, rst_n, wr, rd, stop, slow, blank_set, done, blank, start, irq;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, adata, s;
  logic [15:0] aaddr;
  logic [1:0] sec;
  fcs_op_t op;
  int fails = 0;
  int checks = 0;
  fcs_row_t rows[7];

  fcs_flash_cmd fcs_flash_cmd_inst (.i_clock(clock), .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wdata),
    .i_write(wr), .i_read(rd), .o_rdata(rdata), .i_stop_mode(stop), .i_array_done(done),
    .i_array_blank(blank), .o_array_start(start), .o_array_op(op), .o_array_addr(aaddr),
    .o_array_data(adata), .o_security_state(sec), .o_irq(irq));
  fcs_array_model fcs_array_model_inst (.i_clock(clock), .i_rst_n(rst_n), .i_start(start),
    .i_slow(slow), .i_blank_set(blank_set), .o_done(done), .o_blank(blank));

  initial begin
    clock = 1'h0;
    forever #20 clock = ~clock;
  end

  task automatic give_verdict();
    if (fails == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    wr <= 1'h1;
    addr <= a;
    wdata <= d;
    @(posedge clock);
    wr <= 1'h0;
  endtask
  // read data stand only in the cycle after the read edge
  task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
    @(posedge clock);
    rd <= 1'h1;
    addr <= a;
    @(posedge clock);
    rd <= 1'h0;
    #1 d = rdata;
  endtask
  task automatic launch(input logic [7:0] code, input logic [15:0] a);
    wr_reg(OFF_ADDR_HI, a[15:8]);
    wr_reg(OFF_ADDR_LO, a[7:0]);
    // data tied to the address so a stale buffer shows on the array side
    wr_reg(OFF_DATA, a[7:0] ^ 8'h5a);
    wr_reg(OFF_COMMAND, code);
    wr_reg(OFF_STATUS, 8'h80);
  endtask
  task automatic wait_start(input int n);
    int k;
    for (k = 0; k < n; k++) begin
      @(posedge clock);
      #1;
      if (start === 1'h1) return;
    end
    fails++;
    give_verdict();
  endtask
  task automatic wait_done();
    logic [7:0] st;
    int k;
    for (k = 0; k < 100; k++) begin
      rd_reg(OFF_STATUS, st);
      if (st[BIT_CCF] === 1'h1) return;
    end
    fails++;
    give_verdict();
  endtask

  initial begin
    rst_n = 1'h0;
    wr = 1'h0;
    rd = 1'h0;
    addr = 4'h0;
    wdata = 8'h00;
    stop = 1'h0;
    slow = 1'h0;
    blank_set = 1'h0;
    rows[0] = '{BLANK_CHECK_CODE, 1'h1, 1'h1, OP_BLANK, 8'hc4};
    rows[1] = '{BYTE_PROGRAM_CODE, 1'h0, 1'h1, OP_BYTE, 8'hc0};
    rows[2] = '{BURST_PROGRAM_CODE, 1'h0, 1'h1, OP_BURST, 8'hc0};
    rows[3] = '{PAGE_ERASE_CODE, 1'h0, 1'h1, OP_PAGE, 8'hc0};
    rows[4] = '{MASS_ERASE_CODE, 1'h0, 1'h1, OP_MASS, 8'hc0};
    rows[5] = '{8'h33, 1'h0, 1'h0, OP_NONE, 8'hd0};
    rows[6] = '{BLANK_CHECK_CODE, 1'h0, 1'h1, OP_BLANK, 8'hc0};
    repeat (5) @(posedge clock);
    rst_n <= 1'h1;
    rd_reg(OFF_STATUS, s);
    check(s, 8'hc0);
    check({6'h00, sec}, {6'h00, SEC_SECURED});
    rd_reg(4'hf, s);
    check(s, 8'h00);
    launch(BYTE_PROGRAM_CODE, 16'h0100);
    rd_reg(OFF_STATUS, s);
    check(s, 8'hd0);
    // stale errors cleared before the next launch
    wr_reg(OFF_STATUS, 8'h10);
    rd_reg(OFF_STATUS, s);
    check(s, 8'hc0);
    wr_reg(OFF_DIVIDER, 8'h13);
    foreach (rows[i]) begin
      blank_set <= rows[i].blank;
      launch(rows[i].code, 16'h0100);
      if (rows[i].go) begin
        wait_start(20);
        check({5'h00, op}, {5'h00, rows[i].op});
      end
      wait_done();
      rd_reg(OFF_STATUS, s);
      check(s, rows[i].st);
      if (s[BIT_ACCERR] === 1'h1) wr_reg(OFF_STATUS, 8'h10);
    end
    check({6'h00, sec}, {6'h00, SEC_UNSECURED});
    check({7'h00, irq}, 8'h00);
    wr_reg(OFF_IRQ_MASK, 8'h01);
    repeat (2) @(posedge clock);
    #1 check({7'h00, irq}, 8'h01);
    wr_reg(OFF_IRQ_STATUS, 8'h0f);
    repeat (2) @(posedge clock);
    #1 check({7'h00, irq}, 8'h00);
    wr_reg(OFF_STATUS, 8'h74);
    rd_reg(OFF_STATUS, s);
    check(s, 8'hc0);
    wr_reg(OFF_COMMAND, BYTE_PROGRAM_CODE);
    wr_reg(OFF_STATUS, 8'h80);
    rd_reg(OFF_STATUS, s);
    check(s, 8'hd0);
    wr_reg(OFF_STATUS, 8'h10);
    wr_reg(OFF_PROT, 8'h00);
    launch(PAGE_ERASE_CODE, 16'hfe00);
    rd_reg(OFF_STATUS, s);
    check(s, 8'he0);
    wr_reg(OFF_STATUS, 8'h20);
    rd_reg(OFF_STATUS, s);
    check(s, 8'hc0);
    slow <= 1'h1;
    launch(BYTE_PROGRAM_CODE, 16'h0100);
    wait_start(20);
    @(posedge clock);
    stop <= 1'h1;
    @(posedge clock);
    stop <= 1'h0;
    wait_done();
    rd_reg(OFF_STATUS, s);
    check(s, 8'hd0);
    wr_reg(OFF_STATUS, 8'h10);
    // a second burst waits in the buffer while the first runs
    launch(BURST_PROGRAM_CODE, 16'h0100);
    wait_start(20);
    launch(BURST_PROGRAM_CODE, 16'h0101);
    rd_reg(OFF_STATUS, s);
    check(s, 8'h00);
    wait_start(100);
    check(aaddr[7:0], 8'h01);
    check(adata, 8'h5b);
    rd_reg(OFF_STATUS, s);
    check(s, 8'h80);
    // a single-byte program may not queue behind a running burst
    launch(BYTE_PROGRAM_CODE, 16'h0100);
    rd_reg(OFF_STATUS, s);
    check(s, 8'h90);
    wr_reg(OFF_STATUS, 8'h10);
    wait_done();
    rd_reg(OFF_STATUS, s);
    check(s, 8'hc0);
    give_verdict();
  end
endmodule // tb_fcs_flash_cmd
`default_nettype wire
